// ===== hw/gauge_slave.sv
// gauge_slave: register port of the fuel gauge, slave end of the two-wire link
// assumes scl and sda arrive asynchronously and pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module gauge_slave import two_wire_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  two_wire_if.slave bus,
  input wire logic ld_i,
  input wire logic [7:0] ld_addr_i,
  input wire logic [15:0] ld_data_i,
  output logic reg_wr_o,
  output logic [7:0] reg_wr_addr_o,
  output logic [15:0] reg_wr_data_o,
  output logic busy_o
);

  slv_s s_r;
  slv_s s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_val;

  // byte the master reads at the pointer; past the top or once the pointer has wrapped it is FILL_BYTE
  function automatic logic [7:0] rd_byte(input logic [`MEM_BYTES-1:0][7:0] mem, input logic [7:0] ptr,
                                         input logic wrap);
    if (wrap || ptr > `WR_TOP) begin
      rd_byte = `FILL_BYTE;
    end else begin
      rd_byte = mem[ptr[`MEM_IDX_W-1:0]];
    end
  endfunction : rd_byte

  function automatic logic writable(input logic [7:0] ptr, input logic wrap);
    writable = !wrap && ptr <= `WR_TOP && !(ptr >= `RO_LO && ptr <= `RO_HI);
  endfunction : writable

  // edges are taken from the second sync stage only, so scl rate needs no setting
  assign scl_rise = s_r.scl_sy[1] && !s_r.scl_d;
  assign scl_fall = !s_r.scl_sy[1] && s_r.scl_d;
  assign start_seen = s_r.scl_sy[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_sy[1];
  assign stop_seen = s_r.scl_sy[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_sy[1];
  // a function result cannot be bit-selected, so the byte is named once here
  assign rd_val = rd_byte(s_r.mem, s_r.ptr, s_r.wrap);

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_stb = 1'b0;
    s_nxt.scl_sy = {s_r.scl_sy[0], bus.scl};
    s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
    s_nxt.scl_d = s_r.scl_sy[1];
    s_nxt.sda_d = s_r.sda_sy[1];
    if (start_seen) begin
      // pointer is kept so a read phase continues where the write phase left it
      s_nxt.st = S_RX;
      s_nxt.kind = K_ADDR;
      s_nxt.cnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.pend = 1'b0;
      s_nxt.busy = 1'b1;
    end else if (stop_seen) begin
      s_nxt.st = S_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.pend = 1'b0;
      s_nxt.busy = 1'b0;
    end else begin
      case (s_r.st)
        S_IDLE: begin
          s_nxt.sda_oe = 1'b0;
        end
        S_RX: begin
          if (scl_rise && s_r.cnt < `ACK_SLOT) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda_sy[1]};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == `ACK_SLOT) begin
            // a byte counts only once its eighth bit is in and the slot ends
            s_nxt.st = S_ACK;
            s_nxt.sda_oe = 1'b1;
            case (s_r.kind)
              K_ADDR: begin
                if (s_r.sh[7:1] == `TARGET_BUS_ADDRESS) begin
                  s_nxt.rw = s_r.sh[0];
                end else begin
                  s_nxt.st = S_IDLE;
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.busy = 1'b0;
                end
              end
              K_PTR: begin
                s_nxt.ptr = s_r.sh;
                s_nxt.wrap = 1'b0;
              end
              default: begin
                if (writable(s_r.ptr, s_r.wrap) && !s_r.ptr[0]) begin
                  s_nxt.hold = s_r.sh;
                  s_nxt.pend = 1'b1;
                end else if (writable(s_r.ptr, s_r.wrap) && s_r.pend) begin
                  s_nxt.mem[s_r.ptr[`MEM_IDX_W-1:0] - `MEM_IDX_W'(1)] = s_r.hold;
                  s_nxt.mem[s_r.ptr[`MEM_IDX_W-1:0]] = s_r.sh;
                  s_nxt.wr_stb = 1'b1;
                  s_nxt.wr_addr = {s_r.ptr[7:1], 1'b0};
                  s_nxt.wr_data = {s_r.hold, s_r.sh};
                  s_nxt.pend = 1'b0;
                end else begin
                  s_nxt.pend = 1'b0;
                end
                {s_nxt.wrap, s_nxt.ptr} = {1'b0, s_r.ptr} + 9'h001;
                s_nxt.wrap = s_nxt.wrap | s_r.wrap;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.kind == K_ADDR && s_r.rw == `DIR_READ) begin
              s_nxt.sh = rd_val;
              s_nxt.sda_oe = !rd_val[7];
              s_nxt.st = S_TX;
            end else begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.kind = (s_r.kind == K_ADDR) ? K_PTR : K_DATA;
              s_nxt.st = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (s_r.cnt == `BYTE_LAST_BIT) begin
              s_nxt.sda_oe = 1'b0;
              {s_nxt.wrap, s_nxt.ptr} = {1'b0, s_r.ptr} + 9'h001;
              s_nxt.wrap = s_nxt.wrap | s_r.wrap;
              s_nxt.st = S_MACK;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = !s_r.sh[6];
              s_nxt.cnt = s_r.cnt + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            s_nxt.acked = !s_r.sda_sy[1];
          end else if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.acked) begin
              s_nxt.sh = rd_val;
              s_nxt.sda_oe = !rd_val[7];
              s_nxt.st = S_TX;
            end else begin
              // no-acknowledge hands the data line back to the master
              s_nxt.st = S_IDLE;
            end
          end
        end
        default: begin
          s_nxt.st = S_IDLE;
        end
      endcase
    end
    // the gauge core loads measured values, including read-only registers
    if (ld_i && ld_addr_i < `WR_TOP) begin
      s_nxt.mem[{ld_addr_i[`MEM_IDX_W-1:1], 1'b0}] = ld_data_i[15:8];
      s_nxt.mem[{ld_addr_i[`MEM_IDX_W-1:1], 1'b1}] = ld_data_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
      s_r.scl_sy <= 2'h3;
      s_r.sda_sy <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.sda_s_o = s_r.pin_lvl;
  assign bus.sda_s_oe = s_r.sda_oe;
  assign reg_wr_o = s_r.wr_stb;
  assign reg_wr_addr_o = s_r.wr_addr;
  assign reg_wr_data_o = s_r.wr_data;
  assign busy_o = s_r.busy;

endmodule : gauge_slave

`default_nettype wire

// ===== hw/two_wire_map.svh
// two_wire_map.svh: constants shared by both ends of the two-wire register link
// assumes a 100 MHz system clock on both ends
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

`define TARGET_BUS_ADDRESS 7'h36
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`define WR_TOP 8'h4F
`define RO_LO 8'h02
`define RO_HI 8'h07
`define MEM_BYTES 80
`define MEM_IDX_W 7
`define FILL_BYTE 8'hFF
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 2500
`define QTR_CYC (7'((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS)))

`endif

// ===== hw/two_wire_pkg.sv
// two_wire_pkg: state types of both ends of the two-wire register link
// assumes two_wire_map.svh is on the include path
`include "two_wire_map.svh"

package two_wire_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b010,
    S_TX = 3'b011,
    S_MACK = 3'b100
  } slv_state_e;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR = 2'b01,
    K_DATA = 2'b10
  } byte_kind_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_BIT = 2'b10,
    M_STOP = 2'b11
  } mst_state_e;

  typedef enum logic [2:0] {
    G_ADDR_W = 3'b000,
    G_PTR = 3'b001,
    G_D0 = 3'b010,
    G_D1 = 3'b011,
    G_ADDR_R = 3'b100,
    G_RD0 = 3'b101,
    G_RD1 = 3'b110
  } stage_e;

  typedef enum logic [1:0] {
    C_PROBE = 2'b00,
    C_WRITE = 2'b01,
    C_READ = 2'b10
  } cmd_kind_e;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    slv_state_e st;
    byte_kind_e kind;
    logic rw;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic wrap;
    logic pend;
    logic [7:0] hold;
    logic acked;
    logic sda_oe;
    logic pin_lvl;
    logic busy;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic [`MEM_BYTES-1:0][7:0] mem;
  } slv_s;

  typedef struct packed {
    logic [1:0] sda_sy;
    mst_state_e st;
    logic [1:0] q;
    logic [6:0] qcnt;
    logic [3:0] bitn;
    stage_e stage;
    cmd_kind_e kind;
    logic [7:0] ptr;
    logic [15:0] wdata;
    logic [7:0] sh;
    logic [15:0] rdata;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic pin_lvl;
    logic ready;
    logic rsp_valid;
    logic rsp_nack;
  } mst_s;

endpackage : two_wire_pkg

// ===== hw/two_wire_if.sv
// two_wire_if: the open-drain clock and data wires between master and gauge port
// assumes an external pull-up; a wire reads low while any end enables its driver
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : two_wire_if

`default_nettype wire

// ===== hw/gauge_master.sv
// gauge_master: bus master end that probes, writes and reads one gauge register
// assumes the slave answers within a quarter of the scl period
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module gauge_master import two_wire_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  two_wire_if.master bus,
  input wire logic cmd_valid_i,
  input wire cmd_kind_e cmd_kind_i,
  input wire logic [7:0] cmd_ptr_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic rsp_nack_o,
  output logic [15:0] rsp_rdata_o
);

  mst_s m_r;
  mst_s m_nxt;
  logic tick;
  logic rx_byte;

  assign tick = (m_r.qcnt == `QTR_CYC - 7'h01);
  assign rx_byte = (m_r.stage == G_RD0 || m_r.stage == G_RD1);

  always_comb begin
    logic scl_lvl;
    logic sda_lvl;
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    m_nxt = m_r;
    m_nxt.rsp_valid = 1'b0;
    m_nxt.sda_sy = {m_r.sda_sy[0], bus.sda};
    if (m_r.st != M_IDLE) begin
      m_nxt.qcnt = tick ? 7'h00 : m_r.qcnt + 7'h01;
      m_nxt.q = tick ? m_r.q + 2'h1 : m_r.q;
    end
    case (m_r.st)
      M_IDLE: begin
        if (cmd_valid_i && m_r.ready) begin
          m_nxt.ready = 1'b0;
          m_nxt.kind = cmd_kind_i;
          m_nxt.ptr = cmd_ptr_i;
          m_nxt.wdata = cmd_wdata_i;
          m_nxt.stage = G_ADDR_W;
          m_nxt.sh = {`TARGET_BUS_ADDRESS, `DIR_WRITE};
          m_nxt.nack = 1'b0;
          m_nxt.st = M_START;
        end
      end
      M_START: begin
        if (tick && m_r.q == 2'h3) begin
          m_nxt.st = M_BIT;
          m_nxt.bitn = 4'h0;
        end
      end
      M_BIT: begin
        if (tick && m_r.q == 2'h3 && m_r.bitn != `ACK_SLOT) begin
          m_nxt.sh = {m_r.sh[6:0], m_r.sda_sy[1]};
          m_nxt.bitn = m_r.bitn + 4'h1;
        end else if (tick && m_r.q == 2'h3) begin
          m_nxt.bitn = 4'h0;
          if (!rx_byte && m_r.sda_sy[1]) begin
            m_nxt.nack = 1'b1;
            m_nxt.st = M_STOP;
          end else begin
            case (m_r.stage)
              G_ADDR_W: begin
                m_nxt.stage = G_PTR;
                m_nxt.sh = m_r.ptr;
                if (m_r.kind == C_PROBE) begin
                  m_nxt.st = M_STOP;
                end
              end
              G_PTR: begin
                if (m_r.kind == C_READ) begin
                  m_nxt.stage = G_ADDR_R;
                  m_nxt.sh = {`TARGET_BUS_ADDRESS, `DIR_READ};
                  m_nxt.st = M_START;
                end else begin
                  m_nxt.stage = G_D0;
                  m_nxt.sh = m_r.wdata[15:8];
                end
              end
              G_D0: begin
                m_nxt.stage = G_D1;
                m_nxt.sh = m_r.wdata[7:0];
              end
              G_ADDR_R: begin
                m_nxt.stage = G_RD0;
              end
              G_RD0: begin
                m_nxt.rdata[15:8] = m_r.sh;
                m_nxt.stage = G_RD1;
              end
              G_RD1: begin
                m_nxt.rdata[7:0] = m_r.sh;
                m_nxt.st = M_STOP;
              end
              default: begin
                m_nxt.st = M_STOP;
              end
            endcase
          end
        end
      end
      default: begin
        if (tick && m_r.q == 2'h3) begin
          m_nxt.st = M_IDLE;
          m_nxt.rsp_valid = 1'b1;
          m_nxt.rsp_nack = m_r.nack;
          m_nxt.ready = 1'b1;
        end
      end
    endcase
    // levels for the quarter about to run; restart and start share one shape
    case (m_nxt.st)
      M_START: begin
        scl_lvl = (m_nxt.q == 2'h1 || m_nxt.q == 2'h2);
        sda_lvl = (m_nxt.q < 2'h2);
      end
      M_STOP: begin
        scl_lvl = (m_nxt.q != 2'h0);
        sda_lvl = (m_nxt.q >= 2'h2);
      end
      M_BIT: begin
        scl_lvl = m_nxt.q[1];
        if (m_nxt.bitn == `ACK_SLOT) begin
          sda_lvl = !(m_nxt.stage == G_RD0);
        end else begin
          sda_lvl = (m_nxt.stage == G_RD0 || m_nxt.stage == G_RD1) ? 1'b1 : m_nxt.sh[7];
        end
      end
      default: begin
        scl_lvl = 1'b1;
        sda_lvl = 1'b1;
      end
    endcase
    m_nxt.scl_oe = !scl_lvl;
    m_nxt.sda_oe = !sda_lvl;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m_r <= '0;
      m_r.sda_sy <= 2'h3;
      m_r.ready <= 1'b1;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign bus.scl_o = m_r.pin_lvl;
  assign bus.scl_oe = m_r.scl_oe;
  assign bus.sda_m_o = m_r.pin_lvl;
  assign bus.sda_m_oe = m_r.sda_oe;
  assign cmd_ready_o = m_r.ready;
  assign rsp_valid_o = m_r.rsp_valid;
  assign rsp_nack_o = m_r.rsp_nack;
  assign rsp_rdata_o = m_r.rdata;

endmodule : gauge_master

`default_nettype wire

// ===== tb/two_wire_properties.sv
// two_wire_properties: wire checks on the link between master and gauge port
// assumes the resolved, pulled-up wires of two_wire_if and one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

module two_wire_properties (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int HI_MIN = 120;
  localparam int LO_MIN = 60;
  logic [7:0] hi_cnt_r;
  logic [7:0] lo_cnt_r;
  logic [3:0] rise_cnt_r;
  logic scl_q_r;
  logic sda_q_r;

  // counters saturate so an idle bus never wraps into a false short phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_cnt_r <= 8'hFF;
      lo_cnt_r <= 8'h00;
      rise_cnt_r <= 4'hF;
      scl_q_r <= 1'h1;
      sda_q_r <= 1'h1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      hi_cnt_r <= scl ? hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF} : 8'h00;
      lo_cnt_r <= scl ? 8'h00 : lo_cnt_r + {7'h00, lo_cnt_r != 8'hFF};
      if (scl && scl_q_r && !sda && sda_q_r) begin
        rise_cnt_r <= 4'h0;
      end else if (scl && !scl_q_r && rise_cnt_r != 4'hF) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_SLV_OPEN_DRAIN: assert property (sda_s_oe |-> !sda_s_o)
    else $error("gauge port drives sda high");
  AST_MST_OPEN_DRAIN: assert property ((scl_oe |-> !scl_o) and (sda_m_oe |-> !sda_m_o))
    else $error("master drives a wire high");
  AST_SLV_MOVES_SCL_LOW: assert property ($changed(sda_s_oe) |-> !$past(scl) && !$past(scl, 2))
    else $error("gauge port moved sda while scl high");
  AST_SCL_HIGH_PHASE: assert property ($rose(scl_oe) |-> hi_cnt_r >= HI_MIN)
    else $error("scl high phase too short");
  AST_SCL_LOW_PHASE: assert property ($fell(scl_oe) |-> lo_cnt_r >= LO_MIN)
    else $error("scl low phase too short");
  AST_ACK_AFTER_BYTE: assert property ($rose(sda_s_oe) |-> rise_cnt_r >= 4'h8)
    else $error("gauge port drove sda before a full byte");
  AST_ACK_HOLD: assert property ($rose(sda_s_oe) |=> sda_s_oe [*8])
    else $error("gauge port low pulse too short");
  AST_STOP_RELEASED: assert property (scl && $past(scl) && $rose(sda) |-> !sda_s_oe [*4])
    else $error("gauge port drives sda after stop");
  AST_START_RELEASED: assert property (scl && $past(scl) && $fell(sda) |-> !sda_s_oe && !$past(sda_s_oe))
    else $error("gauge port drives sda at start");

  CVR_ACK: cover property ($rose(sda_s_oe));
  CVR_STOP: cover property (scl && $past(scl) && $rose(sda));
  CVR_RESTART: cover property (scl && $past(scl) && $fell(sda) && rise_cnt_r == 4'hF);
endmodule : two_wire_properties

`default_nettype wire

// ===== tb/fuel_gauge_two_wire_register_port_tb.sv
// fuel_gauge_two_wire_register_port_tb: master and gauge port on one link, a bench-driven second link
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ps
`default_nettype none

module fuel_gauge_two_wire_register_port_tb import two_wire_pkg::*;;
  logic clk_i;
  logic reset_n_i;
  logic cmd_valid_i;
  cmd_kind_e cmd_kind_i;
  logic [7:0] cmd_ptr_i;
  logic [15:0] cmd_wdata_i;
  logic cmd_ready_o;
  logic rsp_valid_o;
  logic rsp_nack_o;
  logic [15:0] rsp_rdata_o;
  logic ld_i;
  logic [7:0] ld_addr_i;
  logic [15:0] ld_data_i;
  logic reg_wr_o;
  logic [7:0] reg_wr_addr_o;
  logic [15:0] reg_wr_data_o;
  logic busy_o;
  logic f_wr;
  logic [15:0] f_wr_data;
  logic [15:0] last_wr;
  logic [15:0] f_last_wr;
  logic [7:0] last_wr_addr;
  int error_cnt;
  int n_compared;
  int cyc;
  int wr_cnt;
  int f_wr_cnt;

  two_wire_if link_if ();
  two_wire_if fault_if ();

  gauge_master gauge_master_i (.clk_i, .reset_n_i, .bus(link_if), .cmd_valid_i, .cmd_kind_i, .cmd_ptr_i,
    .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_nack_o, .rsp_rdata_o);
  gauge_slave gauge_slave_i (.clk_i, .reset_n_i, .bus(link_if), .ld_i, .ld_addr_i, .ld_data_i, .reg_wr_o,
    .reg_wr_addr_o, .reg_wr_data_o, .busy_o);
  // second port faces the bench so it can be fed foreign addresses and cut bytes
  gauge_slave gauge_slave_fault_i (.clk_i, .reset_n_i, .bus(fault_if), .ld_i(1'h0), .ld_addr_i(8'h00),
    .ld_data_i(16'h0000), .reg_wr_o(f_wr), .reg_wr_addr_o(), .reg_wr_data_o(f_wr_data), .busy_o());
  two_wire_properties two_wire_properties_i (.clk_i, .reset_n_i, .scl_o(link_if.scl_o), .scl_oe(link_if.scl_oe),
    .sda_m_o(link_if.sda_m_o), .sda_m_oe(link_if.sda_m_oe), .sda_s_o(link_if.sda_s_o),
    .sda_s_oe(link_if.sda_s_oe), .scl(link_if.scl), .sda(link_if.sda));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  always @(negedge clk_i) begin
    if (reg_wr_o === 1'h1) begin
      wr_cnt++;
      last_wr = reg_wr_data_o;
      last_wr_addr = reg_wr_addr_o;
    end
    if (f_wr === 1'h1) begin
      f_wr_cnt++;
      f_last_wr = f_wr_data;
    end
  end

  // the longest run needs about 72400 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic run(input cmd_kind_e k, input logic [7:0] p, input logic [15:0] d);
    int n;
    cmd_kind_i = k;
    cmd_ptr_i = p;
    cmd_wdata_i = d;
    cmd_valid_i = 1'h1;
    @(negedge clk_i);
    cmd_valid_i = 1'h0;
    chk_bit("ready while busy", 1'h0, cmd_ready_o);
    n = 0;
    while (rsp_valid_o !== 1'h1 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    chk_bit("response", 1'h1, rsp_valid_o);
    chk_bit("ready at response", 1'h1, cmd_ready_o);
  endtask : run

  task automatic quarter();
    repeat (4) @(negedge clk_i);
  endtask : quarter

  // one byte of the bench link, 160 ns per bit; nb below 8 leaves the byte cut short
  task automatic l2_byte(input logic [7:0] v, input int nb, output logic ack);
    for (int i = 0; i <= nb; i++) begin
      if (i == nb && nb < 8) break;
      fault_if.sda_m_oe = (i < nb) ? !v[7 - i] : 1'h0;
      quarter();
      fault_if.scl_oe = 1'h0;
      quarter();
      ack = !fault_if.sda;
      quarter();
      fault_if.scl_oe = 1'h1;
      quarter();
    end
  endtask : l2_byte

  task automatic l2_frame(input logic [47:0] b, input int n, input int cut, output logic all_ack);
    logic a;
    all_ack = 1'h1;
    fault_if.sda_m_oe = 1'h0;
    fault_if.scl_oe = 1'h0;
    quarter();
    fault_if.sda_m_oe = 1'h1;
    quarter();
    fault_if.scl_oe = 1'h1;
    quarter();
    for (int i = 0; i < n; i++) begin
      l2_byte(b[47 - 8 * i -: 8], 8, a);
      all_ack = all_ack & a;
    end
    if (cut > 0) l2_byte(b[47 - 8 * n -: 8], cut, a);
    fault_if.sda_m_oe = 1'h1;
    quarter();
    fault_if.scl_oe = 1'h0;
    quarter();
    fault_if.sda_m_oe = 1'h0;
    quarter();
  endtask : l2_frame

  task automatic t_probe();
    run(C_PROBE, 8'h00, 16'h0000);
    chk_bit("probe nack", 1'h0, rsp_nack_o);
    chk_bit("busy after stop", 1'h0, busy_o);
  endtask : t_probe

  task automatic t_write_read();
    int w0;
    w0 = wr_cnt;
    run(C_WRITE, 8'h08, 16'hA55A);
    chk_bit("write nack", 1'h0, rsp_nack_o);
    chk("commits", 16'(w0 + 1), 16'(wr_cnt));
    chk("commit address", 16'h0008, {8'h00, last_wr_addr});
    chk("commit data", 16'hA55A, last_wr);
    run(C_READ, 8'h08, 16'h0000);
    chk("read back", 16'hA55A, rsp_rdata_o);
  endtask : t_write_read

  task automatic t_read_only();
    int w0;
    w0 = wr_cnt;
    run(C_WRITE, 8'h02, 16'h1234);
    chk("read-only commits", 16'(w0), 16'(wr_cnt));
    run(C_READ, 8'h02, 16'h0000);
    chk("read-only data", 16'h0000, rsp_rdata_o);
  endtask : t_read_only

  task automatic t_top();
    ld_addr_i = 8'h4E;
    ld_data_i = 16'hBEEF;
    ld_i = 1'h1;
    @(negedge clk_i);
    ld_i = 1'h0;
    run(C_READ, 8'h4E, 16'h0000);
    chk("loaded pair", 16'hBEEF, rsp_rdata_o);
    run(C_READ, 8'hFF, 16'h0000);
    chk("past top", 16'h00FF, {8'h00, rsp_rdata_o[7:0]});
  endtask : t_top

  task automatic t_fault();
    logic a;
    int w0;
    w0 = f_wr_cnt;
    l2_frame(48'h6E0000000000, 1, 0, a);
    chk_bit("foreign ack", 1'h0, a);
    l2_frame(48'h6C4E11223344, 6, 0, a);
    chk_bit("all acked", 1'h1, a);
    chk("commits past top", 16'(w0 + 1), 16'(f_wr_cnt));
    chk("pair data", 16'h1122, f_last_wr);
    l2_frame(48'h6C0877000000, 3, 0, a);
    chk("lone byte commits", 16'(w0 + 1), 16'(f_wr_cnt));
    l2_frame(48'h6C0A88990000, 3, 4, a);
    chk("cut byte commits", 16'(w0 + 1), 16'(f_wr_cnt));
  endtask : t_fault

  initial begin
    reset_n_i = 1'h0;
    cmd_valid_i = 1'h0;
    cmd_kind_i = C_PROBE;
    cmd_ptr_i = 8'h00;
    cmd_wdata_i = 16'h0000;
    ld_i = 1'h0;
    ld_addr_i = 8'h00;
    ld_data_i = 16'h0000;
    fault_if.scl_o = 1'h0;
    fault_if.scl_oe = 1'h0;
    fault_if.sda_m_o = 1'h0;
    fault_if.sda_m_oe = 1'h0;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'h1;
    t_probe();
    t_write_read();
    t_read_only();
    t_top();
    t_fault();
    results();
  end
endmodule : fuel_gauge_two_wire_register_port_tb

`default_nettype wire
